// *** design/pwr_sys_pkg.sv ***
// constants, register map and field positions for the sleep and system control block
// assumes an axi4-lite master on the same clock; no other package is needed
package pwr_sys_pkg;
    localparam logic [31:0] PWR_CTRL_IDX   = 32'h5000_0010;
    localparam logic [31:0] SYS_CTRL_IDX   = 32'h5000_0012;
    localparam logic [7:0]  PWR_CTRL_ADDR  = 8'h40;
    localparam logic [7:0]  SYS_CTRL_ADDR  = 8'h48;
    localparam logic [7:0]  PWR_STAT_ADDR  = 8'h4C;
    localparam logic [7:0]  WAKE_CMD_ADDR  = 8'h50;

    localparam logic [15:0] PWR_CTRL_RESET = 16'h000F;
    localparam logic [15:0] PWR_CTRL_WMASK = 16'hFFE7;
    localparam logic [15:0] SYS_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SYS_CTRL_WMASK = 16'h7EC0;

    localparam int B_ECC_KEEP   = 15;
    localparam int B_CACHE_KEEP = 14;
    localparam int B_CLK_STOP   = 13;
    localparam int B_RAM_HI     = 12;
    localparam int B_RAM_LO     = 8;
    localparam int B_DIV_HI     = 7;
    localparam int B_DIV_LO     = 6;
    localparam int B_RST_WAKE   = 5;
    localparam int B_BLE_PD     = 2;
    localparam int B_RADIO_PD   = 1;
    localparam int B_PERIPH_PD  = 0;

    localparam int B_SOFTWARE_RESET_TRIGGER   = 15;
    localparam int B_REMAP      = 14;
    localparam int B_OTP_COPY   = 13;
    localparam int B_FLASH_INIT = 12;
    localparam int B_DEVELOPMENT_PHASE_SEL  = 11;
    localparam int B_CACHE_VIS  = 10;
    localparam int B_TMO_DIS    = 9;
    localparam int B_DEBUG_EN   = 7;
    localparam int B_OTPC_RST   = 6;

    localparam logic [31:0] REMAP_LIMIT    = 32'h0000_00FF;
    localparam logic [31:0] REMAP_BASE     = 32'h07FC_0000;

    localparam int          CLK_HZ         = 25_000_000;
    localparam int          TIMEOUT_US     = 2000;
    localparam int          TIMEOUT_CYC    = CLK_HZ / 1_000_000 * TIMEOUT_US;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [2:0] {
        ST_AWAKE   = 3'b000,
        ST_SLEEP   = 3'b001,
        ST_POWERUP = 3'b010,
        ST_OTPCOPY = 3'b011,
        ST_FLASH   = 3'b100
    } pwr_state_t;
endpackage

// *** design/pulse_stretch.sv ***
// counter that reports when a wait has run its full length
// assumes the caller holds run low while idle
`timescale 1ns/10ps
`default_nettype none
module pulse_stretch #(
    parameter int LIMIT = 50000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // control
    input  wire logic run,
    output logic      expired
);
    logic [31:0] cnt_q;

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_q   <= 32'h0000_0000;
            expired <= 1'b0;
        end else if (cnt_q == 32'(LIMIT - 1)) begin
            expired <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// *** design/pwr_sys_ctrl.sv ***
// sleep, retention, wake and system control registers behind axi4-lite
// assumes one clock; wake and ready inputs come from other domains
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwr_sys_ctrl
    import pwr_sys_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // sleep and wake
    input  wire logic        wake_event,
    input  wire logic        blocks_ready,
    input  wire logic        otp_copy_done,
    input  wire logic        flash_init_done,
    // cpu address path
    input  wire logic [31:0] cpu_addr,
    input  wire logic        ble_reg_access,
    output logic [31:0]      mapped_addr,
    output logic             hard_fault,
    // power and clock controls
    output logic             ecc_ram_keep,
    output logic             cache_keep,
    output logic [4:0]       sys_ram_keep_mask,
    output logic             low_power_clock_en,
    output logic             ble_powerdown,
    output logic             radio_powerdown,
    output logic             peripheral_powerdown,
    output logic [1:0]       otp_copy_div,
    output logic             otp_copy_start,
    output logic             flash_init_start,
    output logic             hw_reset,
    output logic             software_reset_trigger,
    output logic             cache_ram_visible,
    output logic             debug_port_en,
    output logic             otp_ctrl_reset_request,
    input  wire logic        ble_clock_on
);
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] pwr_q;
    logic [15:0] sys_q;
    logic        wake_m_q;
    logic        wake_s_q;
    logic        rdy_m_q;
    logic        rdy_s_q;
    logic        aw_q;
    logic        w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        sleep_req_q;
    logic        timed_out;
    pwr_state_t  state_q;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be, input logic [15:0] wm);
        logic [15:0] v;
        v = old;
        if (be[0]) v[7:0] = d[7:0];
        if (be[1]) v[15:8] = d[15:8];
        merge16 = (v & wm) | (old & ~wm);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers for pins from other domains
    always_ff @(posedge clk) begin
        if (srst) begin
            wake_m_q <= 1'b0;
            wake_s_q <= 1'b0;
            rdy_m_q  <= 1'b0;
            rdy_s_q  <= 1'b0;
        end else begin
            wake_m_q <= wake_event;
            wake_s_q <= wake_m_q;
            rdy_m_q  <= blocks_ready;
            rdy_s_q  <= rdy_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    wire wr_go = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_q          <= 1'b0;
            w_q           <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == PWR_CTRL_ADDR || awaddr_q == SYS_CTRL_ADDR ||
                                 awaddr_q == WAKE_CMD_ADDR || awaddr_q == PWR_STAT_ADDR)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    wire wr_pwr  = wr_go && awaddr_q == PWR_CTRL_ADDR;
    wire wr_sys  = wr_go && awaddr_q == SYS_CTRL_ADDR;
    wire wr_wake = wr_go && awaddr_q == WAKE_CMD_ADDR && wstrb_q[0] && wdata_q[0];

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_q <= PWR_CTRL_RESET;
        end else if (wr_pwr) begin
            pwr_q <= merge16(pwr_q, wdata_q, wstrb_q, PWR_CTRL_WMASK);
        end
    end

    // the reset bit never stores; it only fires one pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            sys_q                  <= SYS_CTRL_RESET;
            software_reset_trigger <= 1'b0;
        end else begin
            software_reset_trigger <= wr_sys && wstrb_q[1] && wdata_q[B_SOFTWARE_RESET_TRIGGER];
            if (wr_sys) begin
                sys_q <= merge16(sys_q, wdata_q, wstrb_q, SYS_CTRL_WMASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep request pends until the sequencer takes it
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_req_q <= 1'b0;
        end else if (wr_wake) begin
            sleep_req_q <= 1'b1;
        end else if (state_q == ST_SLEEP) begin
            sleep_req_q <= 1'b0;
        end
    end

    pulse_stretch #(
        .LIMIT (TIMEOUT_CYCLES)
    ) u_timeout (
        .clk     (clk),
        .srst    (srst),
        .run     (state_q == ST_POWERUP),
        .expired (timed_out)
    );

    // power sequencer: sleep, power-up wait, otp mirror, flash init
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q          <= ST_AWAKE;
            hw_reset         <= 1'b0;
            otp_copy_start   <= 1'b0;
            flash_init_start <= 1'b0;
        end else begin
            hw_reset         <= 1'b0;
            otp_copy_start   <= 1'b0;
            flash_init_start <= 1'b0;
            case (state_q)
                ST_AWAKE: begin
                    if (sleep_req_q) state_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (wake_s_q) state_q <= ST_POWERUP;
                end
                ST_POWERUP: begin
                    // a stuck block must not hang wake-up
                    if (rdy_s_q || (timed_out && !sys_q[B_TMO_DIS])) begin
                        if (pwr_q[B_RST_WAKE]) begin
                            hw_reset <= 1'b1;
                            state_q  <= ST_AWAKE;
                        end else if (sys_q[B_OTP_COPY]) begin
                            otp_copy_start <= !sys_q[B_DEVELOPMENT_PHASE_SEL];
                            state_q        <= ST_OTPCOPY;
                        end else if (sys_q[B_FLASH_INIT]) begin
                            flash_init_start <= 1'b1;
                            state_q          <= ST_FLASH;
                        end else begin
                            state_q <= ST_AWAKE;
                        end
                    end
                end
                ST_OTPCOPY: begin
                    // development_phase_sel still waits for the done strobe so timing matches
                    if (otp_copy_done) begin
                        if (sys_q[B_FLASH_INIT]) begin
                            flash_init_start <= 1'b1;
                            state_q          <= ST_FLASH;
                        end else begin
                            state_q <= ST_AWAKE;
                        end
                    end
                end
                ST_FLASH: begin
                    if (flash_init_done) state_q <= ST_AWAKE;
                end
                default: state_q <= ST_AWAKE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power, retention and clock outputs
    wire in_sleep = state_q == ST_SLEEP;

    always_ff @(posedge clk) begin
        if (srst) begin
            ecc_ram_keep         <= 1'b0;
            cache_keep           <= 1'b0;
            sys_ram_keep_mask    <= 5'h00;
            low_power_clock_en   <= 1'b1;
            ble_powerdown        <= 1'b1;
            radio_powerdown      <= 1'b1;
            peripheral_powerdown <= 1'b1;
            otp_copy_div         <= 2'h0;
            cache_ram_visible    <= 1'b1;
            debug_port_en        <= 1'b0;
            otp_ctrl_reset_request <= 1'b0;
        end else begin
            ecc_ram_keep         <= !in_sleep || pwr_q[B_ECC_KEEP];
            cache_keep           <= !in_sleep || pwr_q[B_CACHE_KEEP];
            sys_ram_keep_mask    <= in_sleep ? pwr_q[B_RAM_HI:B_RAM_LO] : 5'h1F;
            low_power_clock_en   <= !(in_sleep && pwr_q[B_CLK_STOP] && !wake_s_q);
            ble_powerdown        <= pwr_q[B_BLE_PD];
            radio_powerdown      <= pwr_q[B_RADIO_PD];
            peripheral_powerdown <= pwr_q[B_PERIPH_PD];
            otp_copy_div         <= pwr_q[B_DIV_HI:B_DIV_LO];
            cache_ram_visible    <= !sys_q[B_CACHE_VIS];
            debug_port_en        <= sys_q[B_DEBUG_EN];
            otp_ctrl_reset_request <= sys_q[B_OTPC_RST];
        end
    end

    // cpu address remap and ble fault
    always_ff @(posedge clk) begin
        if (srst) begin
            mapped_addr <= 32'h0000_0000;
            hard_fault  <= 1'b0;
        end else begin
            mapped_addr <= (sys_q[B_REMAP] && cpu_addr <= REMAP_LIMIT)
                           ? (REMAP_BASE | cpu_addr) : cpu_addr;
            hard_fault  <= ble_reg_access && (!ble_clock_on || pwr_q[B_BLE_PD]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    PWR_CTRL_ADDR: s_axi_rdata <= {16'h0000, pwr_q};
                    SYS_CTRL_ADDR: s_axi_rdata <= {16'h0000, sys_q};
                    PWR_STAT_ADDR: s_axi_rdata <= {29'h0000_0000, state_q};
                    WAKE_CMD_ADDR: s_axi_rdata <= {31'h0000_0000, sleep_req_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_ble_fault: assert property (@(posedge clk) disable iff (srst)
        ble_reg_access && !ble_clock_on |=> hard_fault) else $error("ble fault missing");
    a_swr_pulse: assert property (@(posedge clk) disable iff (srst)
        software_reset_trigger |=> !software_reset_trigger) else $error("software_reset_trigger stuck");
    a_ecc_gate: assert property (@(posedge clk) disable iff (srst)
        state_q == ST_SLEEP && !pwr_q[B_ECC_KEEP] |=> !ecc_ram_keep) else $error("ecc not gated");
    a_cache_gate: assert property (@(posedge clk) disable iff (srst)
        state_q == ST_SLEEP && !pwr_q[B_CACHE_KEEP] |=> !cache_keep) else $error("cache not gated");
    a_ram_mask: assert property (@(posedge clk) disable iff (srst)
        state_q == ST_SLEEP |=> sys_ram_keep_mask == $past(pwr_q[B_RAM_HI:B_RAM_LO])) else $error("ram mask wrong");
    a_lpclk_run: assert property (@(posedge clk) disable iff (srst)
        !pwr_q[B_CLK_STOP] |=> low_power_clock_en) else $error("lp clock stopped");
    a_remap_addr: assert property (@(posedge clk) disable iff (srst)
        sys_q[B_REMAP] && cpu_addr <= REMAP_LIMIT |=> mapped_addr == (REMAP_BASE | $past(cpu_addr)))
        else $error("remap wrong");
    a_wake_reset: assert property (@(posedge clk) disable iff (srst)
        state_q == ST_POWERUP && rdy_s_q && pwr_q[B_RST_WAKE] |=> hw_reset) else $error("no wake reset");
    a_dev_nocopy: assert property (@(posedge clk) disable iff (srst)
        sys_q[B_DEVELOPMENT_PHASE_SEL] && $stable(sys_q) |=> !otp_copy_start) else $error("dev copy ran");
    a_timeout_go: assert property (@(posedge clk) disable iff (srst)
        state_q == ST_POWERUP && timed_out && !sys_q[B_TMO_DIS] |=> state_q != ST_POWERUP)
        else $error("timeout ignored");
endmodule
`default_nettype wire

// *** dv/power_sleep_system_control_tb.sv ***
// self-checking bench for the sleep and system control block
// assumes the design package is compiled first; bench acts as axi4-lite master
`timescale 1ns/10ps
`default_nettype none
module power_sleep_system_control_tb
    import pwr_sys_pkg::*;
;
////////////////////////////////////////////////////////////////////////////////
logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
logic [7:0]  awaddr, araddr;
logic [31:0] wdata, cpu_addr;
logic [3:0]  wstrb;
logic        wake_event, blocks_ready, otp_copy_done, flash_init_done, ble_reg_access, ble_clock_on;
logic        awready, wready, bvalid, arready, rvalid, hard_fault, ecc_ram_keep, cache_keep;
logic [1:0]  bresp, rresp, otp_copy_div;
logic [31:0] rdata, mapped_addr;
logic [4:0]  sys_ram_keep_mask;
logic        low_power_clock_en, ble_powerdown, radio_powerdown, peripheral_powerdown;
logic        otp_copy_start, flash_init_start, hw_reset, software_reset_trigger;
logic        cache_ram_visible, debug_port_en, otp_ctrl_reset_request;
int          n_fail, tests_run, n_swr, n_hwr, n_otp, n_fls;

// short wake timeout keeps the run brief; expectations follow this value
pwr_sys_ctrl #(.TIMEOUT_CYCLES(20)) i_pwr_sys_ctrl (
    .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_event(wake_event), .blocks_ready(blocks_ready),
    .otp_copy_done(otp_copy_done), .flash_init_done(flash_init_done), .cpu_addr(cpu_addr),
    .ble_reg_access(ble_reg_access), .mapped_addr(mapped_addr), .hard_fault(hard_fault),
    .ecc_ram_keep(ecc_ram_keep), .cache_keep(cache_keep), .sys_ram_keep_mask(sys_ram_keep_mask),
    .low_power_clock_en(low_power_clock_en), .ble_powerdown(ble_powerdown),
    .radio_powerdown(radio_powerdown), .peripheral_powerdown(peripheral_powerdown),
    .otp_copy_div(otp_copy_div), .otp_copy_start(otp_copy_start), .flash_init_start(flash_init_start),
    .hw_reset(hw_reset), .software_reset_trigger(software_reset_trigger),
    .cache_ram_visible(cache_ram_visible), .debug_port_en(debug_port_en),
    .otp_ctrl_reset_request(otp_ctrl_reset_request), .ble_clock_on(ble_clock_on));

always #20 clk = ~clk;

// pulse counters use non-blocking updates so reads after an edge are deterministic
always @(posedge clk) begin
    if (software_reset_trigger === 1'b1) n_swr <= n_swr + 1;
    if (hw_reset === 1'b1) n_hwr <= n_hwr + 1;
    if (otp_copy_start === 1'b1) n_otp <= n_otp + 1;
    if (flash_init_start === 1'b1) n_fls <= n_fls + 1;
end
////////////////////////////////////////////////////////////////////////////////
task automatic stop_test();
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask

task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
        n_fail++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
endtask

task automatic hang(input string nm);
    n_fail++;
    $display("[FAIL] %s expected handshake seen none", nm);
    stop_test();
endtask

task automatic cyc(input int k);
    repeat (k) @(posedge clk);
endtask

task automatic wait_cnt(ref int c, input int tgt, input string nm);
    int n;
    n = 0;
    while (c < tgt) begin
        @(posedge clk);
        n++;
        if (n > 100) hang(nm);
    end
endtask

// entered just after a rising edge; valids held until their own ready
task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rsp);
    int n;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
        @(posedge clk);
        n++;
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (n > 50) hang("bvalid");
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, rsp}, {30'h0, bresp});
    // one idle edge so the next call never re-raises bready in this time step
    @(posedge clk);
endtask

task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
        @(posedge clk);
        n++;
        if (arready === 1'b1) arvalid <= 1'b0;
        if (n > 50) hang("rvalid");
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", d, rdata);
    chk("rresp", {30'h0, rsp}, {30'h0, rresp});
    @(posedge clk);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    {clk, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, cpu_addr} = '0;
    {wake_event, blocks_ready, otp_copy_done, flash_init_done, ble_reg_access} = '0;
    {n_fail, tests_run, n_swr, n_hwr, n_otp, n_fls} = '0;
    wstrb = 4'h3;
    ble_clock_on = 1'b1;
    srst = 1'b1;
    cyc(12);
    srst <= 1'b0;
    @(posedge clk);
    chk("ble_pd", 32'h1, {31'h0, ble_powerdown});
    chk("radio_pd", 32'h1, {31'h0, radio_powerdown});
    chk("periph_pd", 32'h1, {31'h0, peripheral_powerdown});
    axi_rd(PWR_CTRL_ADDR, {16'h0, PWR_CTRL_RESET}, RESP_OKAY);
    axi_rd(SYS_CTRL_ADDR, 32'h0, RESP_OKAY);
    ble_reg_access <= 1'b1;
    cyc(2);
    chk("fault_pd", 32'h1, {31'h0, hard_fault});
    // keep ecc, clock-stop, bank2 only, div 3, reset on wake, all blocks powered
    // clock-stop sleep chosen; bits 4 and 3 are not writable, so bit 3 keeps its reset value of one
    axi_wr(PWR_CTRL_ADDR, 16'hA2E0, RESP_OKAY);
    axi_rd(PWR_CTRL_ADDR, 32'h0000A2E8, RESP_OKAY);
    chk("ble_pd0", 32'h0, {31'h0, ble_powerdown});
    chk("radio_pd0", 32'h0, {31'h0, radio_powerdown});
    chk("periph_pd0", 32'h0, {31'h0, peripheral_powerdown});
    chk("copy_div", 32'h3, {30'h0, otp_copy_div});
    chk("awake_mask", 32'h1F, {27'h0, sys_ram_keep_mask});
    chk("fault_on", 32'h0, {31'h0, hard_fault});
    ble_clock_on <= 1'b0;
    cyc(2);
    chk("fault_clk", 32'h1, {31'h0, hard_fault});
    ble_reg_access <= 1'b0;
    ble_clock_on <= 1'b1;
    axi_wr(SYS_CTRL_ADDR, 16'hC680, RESP_OKAY);
    axi_rd(SYS_CTRL_ADDR, 32'h00004680, RESP_OKAY);
    chk("swr_pulses", 32'h1, n_swr);
    chk("cache_vis0", 32'h0, {31'h0, cache_ram_visible});
    chk("debug_en", 32'h1, {31'h0, debug_port_en});
    cpu_addr <= 32'h0000_00FF;
    cyc(2);
    chk("remap_top", 32'h07FC_00FF, mapped_addr);
    cpu_addr <= 32'h0000_0100;
    cyc(2);
    chk("remap_out", 32'h0000_0100, mapped_addr);
    axi_wr(SYS_CTRL_ADDR, 16'h0040, RESP_OKAY);
    cpu_addr <= 32'h0000_0080;
    cyc(2);
    chk("remap_off", 32'h0000_0080, mapped_addr);
    chk("otpc_req", 32'h1, {31'h0, otp_ctrl_reset_request});
    chk("debug_off", 32'h0, {31'h0, debug_port_en});
    chk("cache_vis1", 32'h1, {31'h0, cache_ram_visible});
    chk("swr_once", 32'h1, n_swr);
    axi_rd(8'h60, 32'h0, RESP_SLVERR);
    axi_wr(8'h60, 16'h1234, RESP_SLVERR);
    // first sleep: clock stopped, wake leads to a hardware reset
    axi_wr(WAKE_CMD_ADDR, 16'h0001, RESP_OKAY);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_SLEEP}, RESP_OKAY);
    chk("ecc_keep", 32'h1, {31'h0, ecc_ram_keep});
    chk("cache_gate", 32'h0, {31'h0, cache_keep});
    chk("sleep_mask", 32'h02, {27'h0, sys_ram_keep_mask});
    chk("lpclk_stop", 32'h0, {31'h0, low_power_clock_en});
    blocks_ready <= 1'b1;
    wake_event <= 1'b1;
    wait_cnt(n_hwr, 1, "hw_reset");
    cyc(2);
    chk("lpclk_wake", 32'h1, {31'h0, low_power_clock_en});
    wake_event <= 1'b0;
    // second sleep: clock runs, blocks never report, timeout then copy and flash init
    axi_wr(PWR_CTRL_ADDR, 16'h5F00, RESP_OKAY);
    axi_wr(SYS_CTRL_ADDR, 16'h3000, RESP_OKAY);
    blocks_ready <= 1'b0;
    axi_wr(WAKE_CMD_ADDR, 16'h0001, RESP_OKAY);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_SLEEP}, RESP_OKAY);
    chk("ecc_gate", 32'h0, {31'h0, ecc_ram_keep});
    chk("cache_keep", 32'h1, {31'h0, cache_keep});
    chk("all_banks", 32'h1F, {27'h0, sys_ram_keep_mask});
    chk("lpclk_run", 32'h1, {31'h0, low_power_clock_en});
    wake_event <= 1'b1;
    cyc(15);
    chk("early_copy", 32'h0, n_otp);
    wait_cnt(n_otp, 1, "otp_copy_start");
    otp_copy_done <= 1'b1;
    @(posedge clk);
    otp_copy_done <= 1'b0;
    wait_cnt(n_fls, 1, "flash_init_start");
    flash_init_done <= 1'b1;
    @(posedge clk);
    flash_init_done <= 1'b0;
    wake_event <= 1'b0;
    cyc(4);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_AWAKE}, RESP_OKAY);
    chk("no_reset", 32'h1, n_hwr);
    // third wake: development_phase_sel, timeout off; start pulse withheld, sequencer still waits for done
    axi_wr(SYS_CTRL_ADDR, 16'h2A00, RESP_OKAY);
    axi_wr(WAKE_CMD_ADDR, 16'h0001, RESP_OKAY);
    wake_event <= 1'b1;
    cyc(40);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_POWERUP}, RESP_OKAY);
    blocks_ready <= 1'b1;
    cyc(6);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_OTPCOPY}, RESP_OKAY);
    chk("dev_no_copy", 32'h1, n_otp);
    otp_copy_done <= 1'b1;
    @(posedge clk);
    otp_copy_done <= 1'b0;
    cyc(2);
    axi_rd(PWR_STAT_ADDR, {29'h0, ST_AWAKE}, RESP_OKAY);
    chk("flash_once", 32'h1, n_fls);
    stop_test();
end
endmodule
`default_nettype wire
